// ===== lsa_params.svh
// Constants of the load/store address unit: codes, field positions, counts.
// Assumes inclusion by the package and the design modules only.
`ifndef LSA_PARAMS_SVH
`define LSA_PARAMS_SVH
`define LSA_REG_PC       4'h0
`define LSA_REG_SR       4'h1
`define LSA_REG_W        5
`define LSA_DCODE_BS     2'h0
`define LSA_DCODE_BU     2'h1
`define LSA_DCODE_HALF   2'h2
`define LSA_DCODE_WIDE   2'h3
`define LSA_WORD_STEP    32'h00000004
`define LSA_DBL_STEP     32'h00000008
`define LSA_INSN_LEN     32'h00000004
`define LSA_PIPE_DEPTH   2
`define LSA_STK_HI       7
`define LSA_STK_LO       2
`define LSA_STATUS_FLAGS 4'hF
`endif

// ===== lsa_pkg.sv
// Types shared by the load/store address unit and its load aligner.
// Assumes the constants header sits in the same folder.
`include "lsa_params.svh"
package lsa_pkg;
  typedef enum logic [2:0] {
    LSA_T_BS = 3'h0,
    LSA_T_BU = 3'h1,
    LSA_T_HU = 3'h2,
    LSA_T_HS = 3'h3,
    LSA_T_W  = 3'h4,
    LSA_T_D  = 3'h5
  } lsa_type_e;
  typedef enum logic [2:0] {
    LSA_M_DISP  = 3'h0,
    LSA_M_ABS   = 3'h1,
    LSA_M_IOD   = 3'h2,
    LSA_M_IOA   = 3'h3,
    LSA_M_NEXT  = 3'h4,
    LSA_M_STACK = 3'h5,
    LSA_M_REG   = 3'h6,
    LSA_M_POST  = 3'h7
  } lsa_mode_e;
  typedef enum logic [1:0] {
    LSA_S_IDLE   = 2'h0,
    LSA_S_SECOND = 2'h1
  } lsa_state_e;
  // One request from the execute stage.
  typedef struct packed {
    logic        valid;
    logic        is_load;
    logic        next_class;
    logic        reg_class;
    logic        post_inc;
    logic [1:0]  dcode;
    logic        dword_reg;
    logic [3:0]  base_sel;
    logic [4:0]  transfer_register;
    logic [31:0] base_value;
    logic [31:0] pc_value;
    logic [31:0] disp;
    logic [31:0] stack_pointer;
    logic [3:0]  status_flags;
  } lsa_req_s;
  // One load pipeline entry.
  typedef struct packed {
    logic        valid;
    logic [4:0]  dest;
    logic [1:0]  addr_lo;
    lsa_type_e   dtype;
  } lsa_entry_s;
  // One memory cycle handed to the memory control logic.
  typedef struct packed {
    logic        valid;
    logic        is_load;
    logic        io_space;
    logic        stack_reg;
    logic        keep_page;
    logic [31:0] addr;
    logic [3:0]  byte_en;
  } lsa_cyc_s;
  // Write back of a load or a base update.
  typedef struct packed {
    logic        valid;
    logic [4:0]  dest;
    logic [31:0] data;
  } lsa_wb_s;
endpackage

// ===== lsa_load_align.sv
// Load data aligner: picks a byte or half-word lane and extends it.
// Assumes read data arrives as a full 32-bit bus word.
`include "lsa_params.svh"
module lsa_load_align
  import lsa_pkg::*;
(
  input  wire logic [31:0] rd_word,
  input  wire logic [1:0]  addr_lo,
  input  wire lsa_type_e   dtype,
  output logic [31:0]      aligned
);
  logic [7:0]  lane_b;
  logic [15:0] lane_h;
  always_comb begin
    lane_b = rd_word[8*addr_lo +: 8];
    lane_h = addr_lo[1] ? rd_word[31:16] : rd_word[15:0];
    case (dtype)
      LSA_T_BS: aligned = {{24{lane_b[7]}}, lane_b};
      LSA_T_BU: aligned = {24'h000000, lane_b};
      LSA_T_HS: aligned = {{16{lane_h[15]}}, lane_h};
      LSA_T_HU: aligned = {16'h0000, lane_h};
      default:  aligned = rd_word;
    endcase
  end
endmodule

// ===== lsa_unit.sv
// Load/store address unit: mode decode, effective address, null check,
// double-word split, two-entry load pipeline with interlock, load write back.
// Assumes load data returns in issue order, one word per rd_valid pulse.
`include "lsa_params.svh"

// How it works
// - Word accesses drop address bits 1:0, half-words drop bit 0.
// - A zero base, except status register, suppresses access and raises pointer trap.
// - Two shared word entries let a double-word run without stalling.
// - Double-word makes two cycles: high word at address, then address plus four.
// - Same-page consecutive cycles are marked for page mode.
// - Memory instructions leave all status flags unchanged.
// - Post-increment uses base, then adds 4 or 8 at the first cycle.
// - Displacement mode adds signed displacement; bit 0 cleared unless byte.
// - Program counter base means the address after the instruction.
// - Status register base gives absolute displacement addressing.
// - I/O displacement clears dis bits 1:0 and keeps page sequence.
// - I/O absolute uses displacement, bits 1:0 zero, keeps page sequence.
// - Next mode uses base, then adds displacement at first cycle.
// - Stack mode below stack pointer goes to memory, else register 7..2.
// - Displacement-class codes map to byte, half, word, double, I/O variants.
// - Next-class code 3 with 10 reserved, 11 is stack word.
// - Byte and half loads pick lane and zero or sign extend.
// - Word and double loads pass data unchanged.
// - Each load that raises no trap pushes register, address bits and type, and starts a cycle.
// - Only a reference to a pending load register stalls the core.
// - Returning data goes to the oldest entry, which is then removed.
module lsa_unit
  import lsa_pkg::*;
#(
  parameter int PAGE_BITS = 10
)(
  input  wire logic        clk_sys,
  input  wire logic        sys_rst,
  input  wire logic        clk_en,
  input  wire lsa_req_s    req,
  input  wire logic [4:0]  ref_reg_a,
  input  wire logic [4:0]  ref_reg_b,
  input  wire logic        mem_ready,
  input  wire logic        rd_valid,
  input  wire logic [31:0] rd_data,
  output logic             req_ready,
  output logic             core_stall,
  output lsa_cyc_s         mem_cyc,
  output lsa_wb_s          load_wb,
  output lsa_wb_s          base_wb,
  output logic             pointer_trap,
  output logic             reserved_trap,
  output logic [3:0]       status_flags_out
);

  typedef struct packed {
    lsa_state_e  state;
    lsa_entry_s  ent0;
    lsa_entry_s  ent1;
    lsa_cyc_s    cyc;
    logic [31:0] second_addr;
    logic [4:0]  second_dest;
    logic        second_load;
    logic        second_io;
    logic        page_valid;
    logic [31:0] last_addr;
    lsa_wb_s     lwb;
    lsa_wb_s     bwb;
    logic        ptrap;
    logic        rtrap;
  } lsa_st_s;

  lsa_st_s st_reg;
  lsa_st_s st_next;

  lsa_type_e   dtype;
  lsa_mode_e   mode;
  logic        reserved;
  logic        base_is_sr;
  logic        base_is_pc;
  logic [31:0] dis_eff;
  logic [31:0] base_eff;
  logic [31:0] ea;
  logic [31:0] upd_val;
  logic        upd_en;
  logic        is_io;
  logic        is_stack_reg;
  logic        null_ptr;
  logic        accept;
  logic [31:0] aligned;
  logic [1:0]  pend_cnt;
  logic        pipe_room;

  // Word and double ignore bits 1:0, half ignores bit 0.
  function automatic logic [31:0] mask_addr(input logic [31:0] a, input lsa_type_e t);
    case (t)
      LSA_T_BS, LSA_T_BU: mask_addr = a;
      LSA_T_HU, LSA_T_HS: mask_addr = {a[31:1], 1'b0};
      default:            mask_addr = {a[31:2], 2'b00};
    endcase
  endfunction

  function automatic logic [3:0] lanes(input logic [1:0] lo, input lsa_type_e t);
    case (t)
      LSA_T_BS, LSA_T_BU: lanes = 4'h1 << lo;
      LSA_T_HU, LSA_T_HS: lanes = lo[1] ? 4'hC : 4'h3;
      default:            lanes = 4'hF;
    endcase
  endfunction

  function automatic logic hits_reg(input lsa_entry_s e, input logic [4:0] r);
    hits_reg = e.valid && (e.dest == r);
  endfunction

  lsa_load_align i_lsa_load_align (
    .rd_word (rd_data),
    .addr_lo (st_reg.ent0.addr_lo),
    .dtype   (st_reg.ent0.dtype),
    .aligned (aligned)
  );

  // Mode and data type decode.
  always_comb begin
    // Register-class modes name a local register, so low codes there mean neither
    // the program counter nor the status register.
    base_is_sr = !req.reg_class && (req.base_sel == `LSA_REG_SR);
    base_is_pc = !req.reg_class && (req.base_sel == `LSA_REG_PC);
    reserved   = 1'b0;
    mode       = LSA_M_DISP;
    dtype      = LSA_T_W;
    if (req.reg_class) begin
      dtype = req.dword_reg ? LSA_T_D : LSA_T_W;
      mode  = req.post_inc ? LSA_M_POST : LSA_M_REG;
    end else begin
      case (req.dcode)
        `LSA_DCODE_BS:  dtype = LSA_T_BS;
        `LSA_DCODE_BU:  dtype = LSA_T_BU;
        `LSA_DCODE_HALF: dtype = req.disp[0] ? LSA_T_HS : LSA_T_HU;
        default:        dtype = req.disp[0] ? LSA_T_D : LSA_T_W;
      endcase
      if (req.next_class) begin
        mode = LSA_M_NEXT;
        if (req.dcode == `LSA_DCODE_WIDE && req.disp[1]) begin
          reserved = !req.disp[0];
          mode     = LSA_M_STACK;
          dtype    = LSA_T_W;
        end
      end else if (req.dcode == `LSA_DCODE_WIDE && req.disp[1]) begin
        mode = base_is_sr ? LSA_M_IOA : LSA_M_IOD;
      end else begin
        mode = base_is_sr ? LSA_M_ABS : LSA_M_DISP;
      end
    end
  end

  // Effective address and base update.
  always_comb begin
    dis_eff = req.disp;
    if (mode == LSA_M_IOD || mode == LSA_M_IOA || mode == LSA_M_STACK)
      dis_eff = {req.disp[31:2], 2'b00};
    else if (dtype != LSA_T_BS && dtype != LSA_T_BU)
      dis_eff = {req.disp[31:1], 1'b0};
    base_eff = base_is_pc ?
               req.pc_value + `LSA_INSN_LEN : req.base_value;
    case (mode)
      LSA_M_DISP, LSA_M_IOD: ea = base_eff + dis_eff;
      LSA_M_ABS, LSA_M_IOA:  ea = dis_eff;
      default:               ea = req.base_value;
    endcase
    ea = mask_addr(ea, dtype);
    upd_en  = (mode == LSA_M_POST || mode == LSA_M_NEXT || mode == LSA_M_STACK);
    upd_val = (mode == LSA_M_POST) ?
              req.base_value + ((dtype == LSA_T_D) ? `LSA_DBL_STEP : `LSA_WORD_STEP)
              : req.base_value + dis_eff;
    is_io        = (mode == LSA_M_IOD || mode == LSA_M_IOA);
    is_stack_reg = (mode == LSA_M_STACK) && (ea >= req.stack_pointer);
    // A program counter base is checked on its own value, not on the base field.
    null_ptr     = !base_is_sr && !(mode == LSA_M_ABS || mode == LSA_M_IOA) &&
                   ((base_is_pc ? req.pc_value : req.base_value) == 32'h00000000);
  end

  // Load pipeline occupancy and interlock.
  always_comb begin
    pend_cnt   = 2'(st_reg.ent0.valid) + 2'(st_reg.ent1.valid);
    // A double-word load must leave both entries free for its second word, or the
    // second push would overwrite a pending entry.
    pipe_room  = (pend_cnt == 2'h0) ||
                 (pend_cnt == 2'h1 && (!(req.is_load && dtype == LSA_T_D) || rd_valid)) ||
                 (pend_cnt == 2'h2 && rd_valid && !(req.is_load && dtype == LSA_T_D));
    req_ready  = (st_reg.state == LSA_S_IDLE) && (!st_reg.cyc.valid || mem_ready) &&
                 (pipe_room || !req.is_load);
    accept     = clk_en && req.valid && req_ready;
    core_stall = hits_reg(st_reg.ent0, ref_reg_a) || hits_reg(st_reg.ent1, ref_reg_a) ||
                 hits_reg(st_reg.ent0, ref_reg_b) || hits_reg(st_reg.ent1, ref_reg_b);
  end

  always_comb begin
    st_next     = st_reg;
    st_next.lwb = '0;
    st_next.bwb = '0;
    st_next.ptrap = 1'b0;
    st_next.rtrap = 1'b0;
    if (st_reg.cyc.valid && mem_ready) begin
      st_next.cyc.valid = 1'b0;
      st_next.page_valid = !st_reg.cyc.io_space && !st_reg.cyc.stack_reg ?
                           1'b1 : st_reg.page_valid;
      if (!st_reg.cyc.io_space && !st_reg.cyc.stack_reg)
        st_next.last_addr = st_reg.cyc.addr;
    end
    if (rd_valid && st_reg.ent0.valid) begin
      st_next.lwb  = '{valid: 1'b1, dest: st_reg.ent0.dest, data: aligned};
      st_next.ent0 = st_reg.ent1;
      st_next.ent1 = '0;
    end
    case (st_reg.state)
      LSA_S_IDLE: begin
        if (accept) begin
          if (upd_en) st_next.bwb = '{valid: 1'b1, dest: {1'b0, req.base_sel}, data: upd_val};
          if (reserved) begin
            st_next.rtrap = 1'b1;
          end else if (null_ptr) begin
            st_next.ptrap = 1'b1;
          end else begin
            st_next.cyc.valid     = 1'b1;
            st_next.cyc.is_load   = req.is_load;
            st_next.cyc.io_space  = is_io;
            st_next.cyc.stack_reg = is_stack_reg;
            st_next.cyc.addr      = is_stack_reg ?
              32'({ea[`LSA_STK_HI:`LSA_STK_LO], 2'b00}) : ea;
            // Lanes follow the final address, so a program counter base picks them right.
            st_next.cyc.byte_en   = lanes(ea[1:0], dtype);
            st_next.cyc.keep_page = is_io || (st_next.page_valid &&
              (ea[31:PAGE_BITS] == st_next.last_addr[31:PAGE_BITS]));
            if (req.is_load) begin
              if (st_next.ent0.valid)
                st_next.ent1 = '{valid: 1'b1, dest: req.transfer_register,
                                 addr_lo: ea[1:0], dtype: dtype};
              else
                st_next.ent0 = '{valid: 1'b1, dest: req.transfer_register,
                                 addr_lo: ea[1:0], dtype: dtype};
            end
            if (dtype == LSA_T_D) begin
              st_next.state       = LSA_S_SECOND;
              st_next.second_addr = ea + `LSA_WORD_STEP;
              st_next.second_dest = req.transfer_register + 5'h01;
              st_next.second_load = req.is_load;
              st_next.second_io   = is_io;
            end
          end
        end
      end
      LSA_S_SECOND: begin
        if (clk_en && (!st_reg.cyc.valid || mem_ready)) begin
          st_next.state         = LSA_S_IDLE;
          st_next.cyc.valid     = 1'b1;
          st_next.cyc.is_load   = st_reg.second_load;
          st_next.cyc.io_space  = st_reg.second_io;
          st_next.cyc.stack_reg = 1'b0;
          st_next.cyc.addr      = st_reg.second_addr;
          st_next.cyc.byte_en   = 4'hF;
          st_next.cyc.keep_page = st_reg.second_io || (st_next.page_valid &&
            (st_reg.second_addr[31:PAGE_BITS] == st_next.last_addr[31:PAGE_BITS]));
          if (st_reg.second_load) begin
            if (st_next.ent0.valid)
              st_next.ent1 = '{valid: 1'b1, dest: st_reg.second_dest,
                               addr_lo: 2'b00, dtype: LSA_T_D};
            else
              st_next.ent0 = '{valid: 1'b1, dest: st_reg.second_dest,
                               addr_lo: 2'b00, dtype: LSA_T_D};
          end
        end
      end
      default: st_next.state = LSA_S_IDLE;
    endcase
  end

  always_ff @(posedge clk_sys or posedge sys_rst) begin
    if (sys_rst) begin
      st_reg <= '0;
    end else if (clk_en) begin
      st_reg <= st_next;
    end
  end

  assign mem_cyc          = st_reg.cyc;
  assign load_wb          = st_reg.lwb;
  assign base_wb          = st_reg.bwb;
  assign pointer_trap     = st_reg.ptrap;
  assign reserved_trap    = st_reg.rtrap;
  assign status_flags_out = req.status_flags;

  a_null_suppress: assert property (@(posedge clk_sys) disable iff (sys_rst)
    clk_en && accept && null_ptr && !reserved && st_reg.state == LSA_S_IDLE
    |=> pointer_trap && !(mem_cyc.valid && $changed(mem_cyc.addr)))
    else $error("null base did not trap");
  a_dword_second: assert property (@(posedge clk_sys) disable iff (sys_rst)
    clk_en && accept && dtype == LSA_T_D && !null_ptr && !reserved
    |=> st_reg.state == LSA_S_SECOND && st_reg.second_addr == mem_cyc.addr + 32'h4)
    else $error("second word address wrong");
  a_word_align: assert property (@(posedge clk_sys) disable iff (sys_rst)
    clk_en && accept && dtype == LSA_T_W && !is_stack_reg && !null_ptr && !reserved
    |=> mem_cyc.addr[1:0] == 2'b00)
    else $error("word address not aligned");
  a_post_step: assert property (@(posedge clk_sys) disable iff (sys_rst)
    clk_en && accept && mode == LSA_M_POST && dtype == LSA_T_D
    |=> base_wb.valid && base_wb.data == $past(req.base_value) + 32'h8)
    else $error("post increment step wrong");
  a_flags_kept: assert property (@(posedge clk_sys) disable iff (sys_rst)
    status_flags_out == req.status_flags)
    else $error("status flags altered");
  a_wb_oldest: assert property (@(posedge clk_sys) disable iff (sys_rst)
    clk_en && rd_valid && st_reg.ent0.valid
    |=> load_wb.valid && load_wb.dest == $past(st_reg.ent0.dest))
    else $error("write back not to oldest entry");
  a_stall_pending: assert property (@(posedge clk_sys) disable iff (sys_rst)
    st_reg.ent0.valid && ref_reg_a == st_reg.ent0.dest |-> core_stall)
    else $error("missing interlock stall");
  a_pipe_depth: assert property (@(posedge clk_sys) disable iff (sys_rst)
    st_reg.ent1.valid |-> st_reg.ent0.valid)
    else $error("load pipeline out of order");
  a_pipe_room: assert property (@(posedge clk_sys) disable iff (sys_rst)
    clk_en && st_reg.state == LSA_S_SECOND && st_reg.second_load &&
    (!st_reg.cyc.valid || mem_ready) |-> !st_reg.ent1.valid || rd_valid)
    else $error("second load word found no pipeline entry");
  a_io_keep_page: assert property (@(posedge clk_sys) disable iff (sys_rst)
    mem_cyc.valid && mem_cyc.io_space |-> mem_cyc.keep_page)
    else $error("io cycle broke page sequence");
  a_reserved_trap: assert property (@(posedge clk_sys) disable iff (sys_rst)
    clk_en && accept && reserved |=> reserved_trap)
    else $error("reserved code not trapped");

  c_dword_load: cover property (@(posedge clk_sys) disable iff (sys_rst)
    accept && req.is_load && dtype == LSA_T_D ##1 st_reg.state == LSA_S_SECOND);
  c_stall: cover property (@(posedge clk_sys) disable iff (sys_rst) core_stall);
  c_stack_reg: cover property (@(posedge clk_sys) disable iff (sys_rst)
    mem_cyc.valid && mem_cyc.stack_reg);
  c_ptr_trap: cover property (@(posedge clk_sys) disable iff (sys_rst) pointer_trap);
endmodule

// ===== lsa_mem_model.sv
// Behavioural memory control partner: takes memory cycles, returns load words.
// Assumes the unit's cycle and read ports; when slow it accepts and answers sparsely.
module lsa_mem_model
  import lsa_pkg::*;
(
  input  wire logic     clk_sys,
  input  wire logic     sys_rst,
  input  wire logic     slow,
  input  wire lsa_cyc_s mem_cyc,
  output logic          mem_ready,
  output logic          rd_valid,
  output logic [31:0]   rd_data
);
  timeunit 1ns;
  timeprecision 1ns;
  logic [31:0] rq[$];
  int          tick;
  function automatic logic [31:0] word_at(input logic [31:0] a);
    return {~a[15:0], a[15:0]};
  endfunction
  initial begin
    mem_ready = 1'b0;
    rd_valid  = 1'b0;
    rd_data   = 32'h0;
    tick      = 0;
  end
  // Words leave strictly in the order their cycles were taken.
  always @(posedge clk_sys) begin
    if (sys_rst) begin
      rq.delete();
    end else if (mem_ready && mem_cyc.valid && mem_cyc.is_load) begin
      rq.push_back(word_at({mem_cyc.addr[31:2], 2'b00}));
    end
    #1;
    tick = tick + 1;
    if (rq.size() > 0 && (!slow || tick[0])) begin
      rd_valid = 1'b1;
      rd_data  = rq.pop_front();
    end else begin
      // An idle read bus flips every bit each cycle, so every second idle cycle shows the last word again.
      rd_valid = 1'b0;
      rd_data  = ~rd_data;
    end
    mem_ready = !sys_rst && mem_cyc.valid && (!slow || tick[1]);
  end
endmodule

// ===== lsa_unit_tb.sv
// Self-checking bench for the load/store address unit.
// Assumes the memory partner model answers in order; runs loads only.
module lsa_unit_tb;
  import lsa_pkg::*;
  timeunit 1ns;
  timeprecision 1ns;
  logic clk_sys, sys_rst, clk_en, slow, mem_ready, rd_valid, req_ready, core_stall;
  logic pointer_trap, reserved_trap, kp;
  logic [4:0]  ref_reg_a, ref_reg_b;
  logic [31:0] rd_data;
  logic [3:0]  status_flags_out;
  lsa_req_s    req, r;
  lsa_cyc_s    mem_cyc;
  lsa_wb_s     load_wb, base_wb;
  logic [36:0] cq[$], wq[$], bq[$];
  int          bad_count, checks, pt, rt;
  lsa_unit i_lsa_unit (.clk_sys(clk_sys), .sys_rst(sys_rst), .clk_en(clk_en), .req(req),
    .ref_reg_a(ref_reg_a), .ref_reg_b(ref_reg_b), .mem_ready(mem_ready),
    .rd_valid(rd_valid), .rd_data(rd_data), .req_ready(req_ready),
    .core_stall(core_stall), .mem_cyc(mem_cyc), .load_wb(load_wb), .base_wb(base_wb),
    .pointer_trap(pointer_trap), .reserved_trap(reserved_trap),
    .status_flags_out(status_flags_out));
  lsa_mem_model i_lsa_mem_model (.clk_sys(clk_sys), .sys_rst(sys_rst), .slow(slow),
    .mem_cyc(mem_cyc), .mem_ready(mem_ready), .rd_valid(rd_valid), .rd_data(rd_data));
  initial begin
    clk_sys = 1'b0;
    forever #25 clk_sys = ~clk_sys;
  end
  always @(posedge clk_sys) begin
    if (mem_cyc.valid && mem_ready) begin
      cq.push_back(cy(mem_cyc.io_space, mem_cyc.stack_reg, mem_cyc.addr));
      kp = mem_cyc.keep_page;
    end
    if (load_wb.valid) wq.push_back({load_wb.dest, load_wb.data});
    if (base_wb.valid) bq.push_back({base_wb.dest, base_wb.data});
    if (pointer_trap) pt++;
    if (reserved_trap) rt++;
  end
  function automatic logic [31:0] w(input logic [31:0] a);
    return {~a[15:0], a[15:0]};
  endfunction
  function automatic logic [36:0] cy(input logic io, input logic st, input logic [31:0] a);
    return {3'h0, io, st, a};
  endfunction
  task chk(input string nm, input logic [36:0] e, input logic [36:0] g);
    checks++;
    if (g !== e) begin
      bad_count++;
      $display("CHECK FAILED %s expected %h seen %h", nm, e, g);
    end
  endtask
  task automatic pop(ref logic [36:0] q[$], input string nm, input logic [36:0] e);
    int n;
    n = 0;
    while (q.size() == 0 && n < 100) begin
      @(posedge clk_sys);
      n++;
    end
    if (q.size() == 0) q.push_back('x);
    #1 chk(nm, e, q.pop_front());
  endtask
  task test_done;
    $display("comparisons %0d mismatches %0d", checks, bad_count);
    if (bad_count == 0 && checks > 0) $display("No errors found");
    else $display("Errors were found");
    $finish;
  endtask
  task nr;
    r = '0;
    r.valid = 1'b1;
    r.is_load = 1'b1;
    r.dcode = 2'h3;
    r.base_sel = 4'h5;
    r.transfer_register = 5'h06;
    r.stack_pointer = 32'hFFFF0000;
    r.status_flags = 4'hA;
  endtask
  task go;
    int n;
    @(posedge clk_sys);
    #1 req = r;
    #1 chk("flags", {33'h0, r.status_flags}, {33'h0, status_flags_out});
    n = 0;
    // Ready is judged between edges, once every input of the cycle has settled.
    while (req_ready !== 1'b1 && n < 50) begin
      @(posedge clk_sys);
      #2 n++;
    end
    if (req_ready !== 1'b1) chk("req_ready", 37'h1, 37'h0);
    @(posedge clk_sys);
    #1 req.valid = 1'b0;
  endtask
  task flush;
    repeat (8) @(posedge clk_sys);
    #2;
    cq.delete();
    wq.delete();
    bq.delete();
    pt = 0;
    rt = 0;
  endtask
  task t_disp;
    flush();
    nr();
    r.base_value = 32'h00001E30;
    r.disp = 32'h00000008;
    go();
    pop(cq, "cyc", cy(0, 0, 32'h00001E38));
    pop(wq, "wb", {5'h06, w(32'h00001E38)});
    r.base_sel = 4'h0;
    r.pc_value = 32'h00004000;
    r.disp = 32'h00000010;
    go();
    pop(cq, "cyc_pc", cy(0, 0, 32'h00004014));
    chk("page_break", 37'h0, kp);
    r.base_sel = 4'h5;
    r.disp = 32'h00000009;
    go();
    pop(cq, "dbl_hi", cy(0, 0, 32'h00001E38));
    pop(cq, "dbl_lo", cy(0, 0, 32'h00001E3C));
    pop(wq, "wb_pc", {5'h06, w(32'h00004014)});
    pop(wq, "wb_hi", {5'h06, w(32'h00001E38)});
    pop(wq, "wb_lo", {5'h07, w(32'h00001E3C)});
  endtask
  task t_ext;
    logic [7:0]  b;
    logic [15:0] h;
    flush();
    for (int k = 0; k < 6; k++) begin
      for (int s = 0; s < 2; s++) begin
        nr();
        r.base_value = 32'h00002000;
        r.dcode = (k < 4) ? (s ? 2'h0 : 2'h1) : 2'h2;
        r.disp = (k < 4) ? k : 2 * (k - 4) + s;
        b = 8'(w(32'h00002000) >> (8 * k));
        h = 16'(w(32'h00002000) >> (16 * (k - 4)));
        go();
        pop(cq, "cyc_ext", cy(0, 0, 32'h00002000 + ((k < 4) ? k : 2 * (k - 4))));
        if (k < 4) pop(wq, "byte", {5'h06, s ? {{24{b[7]}}, b} : {24'h0, b}});
        else pop(wq, "half", {5'h06, s ? {{16{h[15]}}, h} : {16'h0, h}});
      end
    end
  endtask
  task t_abs;
    flush();
    nr();
    r.base_sel = 4'h1;
    r.dcode = 2'h2;
    r.disp = 32'h00000101;
    go();
    pop(cq, "abs", cy(0, 0, 32'h00000100));
    r.dcode = 2'h3;
    r.disp = 32'h000000F2;
    go();
    pop(cq, "ioa", cy(1, 0, 32'h000000F0));
    r.base_sel = 4'h5;
    r.base_value = 32'h00001000;
    r.disp = 32'h0000000E;
    go();
    pop(cq, "iod", cy(1, 0, 32'h0000100C));
    r.base_value = 32'h0;
    r.disp = 32'h00000008;
    go();
    repeat (6) @(posedge clk_sys);
    #1 chk("ptr_trap", 37'h1, pt);
    chk("no_cycle", 37'h0, cq.size());
  endtask
  task t_post;
    flush();
    nr();
    r.reg_class = 1'b1;
    r.post_inc = 1'b1;
    r.base_value = 32'h00003000;
    go();
    pop(cq, "post_w", cy(0, 0, 32'h00003000));
    pop(bq, "post_w_base", {5'h05, 32'h00003004});
    r.dword_reg = 1'b1;
    go();
    pop(cq, "post_d0", cy(0, 0, 32'h00003000));
    pop(bq, "post_d_base", {5'h05, 32'h00003008});
    pop(cq, "post_d1", cy(0, 0, 32'h00003004));
    chk("page_mode", 37'h1, kp);
  endtask
  task t_next;
    flush();
    nr();
    r.next_class = 1'b1;
    r.dcode = 2'h0;
    r.base_value = 32'h00001000;
    r.disp = 32'hFFFFFFFD;
    go();
    pop(cq, "next_b", cy(0, 0, 32'h00001000));
    pop(bq, "next_b_base", {5'h05, 32'h00000FFD});
    r.dcode = 2'h2;
    r.disp = 32'h00000005;
    go();
    pop(bq, "next_h_base", {5'h05, 32'h00001004});
    r.dcode = 2'h3;
    r.disp = 32'h00000002;
    go();
    repeat (4) @(posedge clk_sys);
    #1 chk("rsv_trap", 37'h1, rt);
    flush();
    r.disp = 32'h0000000B;
    r.stack_pointer = 32'h00002000;
    go();
    pop(cq, "stk_mem", cy(0, 0, 32'h00001000));
    pop(bq, "stk_base", {5'h05, 32'h00001008});
    r.base_value = 32'h000023A4;
    go();
    pop(cq, "stk_reg", cy(0, 1, 32'h000000A4));
    pop(bq, "stk_reg_base", {5'h05, 32'h000023AC});
  endtask
  task t_stall;
    flush();
    slow = 1'b1;
    nr();
    r.transfer_register = 5'h09;
    r.base_value = 32'h00000100;
    ref_reg_a = 5'h09;
    go();
    #1 chk("stall_hit", 37'h1, core_stall);
    ref_reg_a = 5'h0A;
    #1 chk("stall_miss", 37'h0, core_stall);
    ref_reg_b = 5'h09;
    #1 chk("stall_b", 37'h1, core_stall);
    pop(wq, "wb_slow", {5'h09, w(32'h00000100)});
    #2 chk("stall_free", 37'h0, core_stall);
    ref_reg_b = 5'h00;
    slow = 1'b0;
  endtask
  initial begin
    #(50 * 20000);
    bad_count++;
    test_done();
  end
  initial begin
    sys_rst = 1'b1;
    clk_en = 1'b1;
    slow = 1'b0;
    ref_reg_a = 5'h00;
    ref_reg_b = 5'h00;
    req = '0;
    bad_count = 0;
    checks = 0;
    repeat (20) @(posedge clk_sys);
    #1 sys_rst = 1'b0;
    t_disp();
    t_ext();
    t_abs();
    t_post();
    t_next();
    t_stall();
    flush();
    test_done();
  end
endmodule
